// File: inc/usart_pkg.sv
/*
 * Shared constants, state types and frame helpers of the serial data path.
 * Assumes a character of at most nine bits and a frame of at most 13 bits.
 */
package usart_pkg;

	localparam int DATA_W    = 9;
	localparam int FRAME_W   = 13;
	localparam int RX_W      = 11;
	localparam int BAUD_W    = 12;
	localparam int CFG_W     = 21;
	localparam int STORE_AW  = 1;

	localparam logic [2:0] CHAR_SIZE_9     = 3'h7;
	localparam logic [3:0] CHAR_BITS_MIN   = 4'h5;
	localparam logic [3:0] CHAR_BITS_BYTE  = 4'h8;
	localparam logic [3:0] CHAR_BITS_NINE  = 4'h9;
	localparam logic [3:0] RX_BITS         = 4'hb;
	localparam logic [3:0] STOP_ONE        = 4'h1;
	localparam logic [4:0] OS_NORMAL       = 5'h10;
	localparam logic [4:0] OS_DOUBLE       = 5'h08;
	localparam logic [1:0] STORE_FULL      = 2'h2;
	localparam logic       LINE_IDLE       = 1'b1;
	localparam logic       START_BIT       = 1'b0;

	typedef enum logic [1:0] {
		TX_IDLE  = 2'b01,
		TX_SHIFT = 2'b10
	} tx_state_e;

	typedef enum logic [2:0] {
		RX_IDLE  = 3'b001,
		RX_START = 3'b010,
		RX_DATA  = 3'b100
	} rx_state_e;

	// data bits per character; the unused codes fall back to eight
	function automatic logic [3:0] char_bits(input logic [2:0] code);
		if (code == CHAR_SIZE_9)
			char_bits = CHAR_BITS_NINE;
		else if (code[2])
			char_bits = CHAR_BITS_BYTE;
		else
			char_bits = CHAR_BITS_MIN + {2'h0, code[1:0]};
	endfunction

	function automatic logic [8:0] mask_char(input logic [8:0] d,
			input logic [2:0] code);
		logic [3:0] n;
		n = char_bits(code);
		for (int i = 0; i < DATA_W; i++)
			mask_char[i] = d[i] & (i < int'(n));
	endfunction

	// start, data lsb first, optional parity, then stop bits (all ones)
	function automatic logic [12:0] build_frame(input logic [8:0] d,
			input logic [2:0] code, input logic par_en,
			input logic odd);
		logic [3:0] n;
		n = char_bits(code);
		build_frame = '1;
		build_frame[0] = START_BIT;
		for (int i = 0; i < DATA_W; i++)
			if (i < int'(n))
				build_frame[i + 1] = d[i];
		if (par_en)
			build_frame[int'(n) + 1] = (^d) ^ odd;
	endfunction

endpackage

// File: verilog/rx_char_store.sv
/*
 * Two-entry store of received characters with a registered read port.
 * Assumes the owner keeps the pointers; a write to the entry being
 * addressed for reading is passed straight to the read register.
 */
`timescale 1ns/100ps
`default_nettype none

module rx_char_store
	import usart_pkg::*;
(
	// clock
	input  wire logic                clk,
	// write side
	input  wire logic                wr_en,
	input  wire logic [STORE_AW-1:0] wr_addr,
	input  wire logic [DATA_W-1:0]   wr_data,
	// read side
	input  wire logic [STORE_AW-1:0] rd_addr,
	output var  logic [DATA_W-1:0]   rd_data
);

	logic [DATA_W-1:0] mem [2**STORE_AW];

	always_ff @(posedge clk) begin
		if (wr_en)
			mem[wr_addr] <= wr_data;
	end

	always_ff @(posedge clk) begin
		if (wr_en && wr_addr == rd_addr)
			rd_data <= wr_data;
		else
			rd_data <= mem[rd_addr];
	end

endmodule

`default_nettype wire

// File: verilog/usart_tx_rx_datapath.sv
/*
 * Transmit and receive data paths of the serial port: transmit buffer,
 * shift registers, flags, interrupt requests and receive store.
 * Assumes the link clock runs free; frame settings stay still while a
 * frame is in flight.
 */
// Functional notes
// - enabled transmitter owns and drives transmit pin
// - sync mode transmitter uses external clock
// - data write loads buffer, starts sending
// - buffer moves to shifter idle or after stop
// - shifter sends frame at divisor or clock
// - unused upper bits of written byte ignored
// - empty flag high exactly when buffer empty
// - empty interrupt requested while flag set
// - data write clears empty flag until moved
// - complete flag sets after frame, buffer empty
// - complete flag clears on service or write-one
// - complete interrupt requested when flag sets
// - parity inserted before first stop when enabled
// - disable waits for empty shifter and buffer
// - enabled receiver owns receive pin
// - sync mode receiver uses external clock
// - valid start bit begins frame capture
// - second stop bit ignored by receiver
// - first stop moves frame into buffer
// - unused upper received bits read zero
// - low start, lsb first, parity, high stops
// - parity xor of data, inverted when odd
// - receive flag while unread; disable flushes
// - receive store holds two characters
`timescale 1ns/100ps
`default_nettype none

module usart_tx_rx_datapath
	import usart_pkg::*;
(
	// clocks and reset
	input  wire logic              core_clk,
	input  wire logic              srst,
	input  wire logic              external_transfer_clock_pin,
	// frame configuration
	input  wire logic              transmitter_enable_bit,
	input  wire logic              receiver_enable_bit,
	input  wire logic              sync_mode,
	input  wire logic              double_speed_bit,
	input  wire logic [2:0]        character_size_code,
	input  wire logic              parity_enable_bit,
	input  wire logic              parity_type_bit,
	input  wire logic              stop_bit_count_select,
	input  wire logic [3:0]        baud_divisor_high,
	input  wire logic [7:0]        baud_divisor_low,
	// shared data location
	input  wire logic              data_wr,
	input  wire logic [7:0]        wr_data,
	input  wire logic              ninth_transmit_bit,
	input  wire logic              data_rd,
	output var  logic [7:0]        rd_data,
	output var  logic              ninth_receive_bit,
	// status and interrupt requests
	input  wire logic              empty_interrupt_enable,
	input  wire logic              transmit_complete_irq_enable,
	input  wire logic              txc_write_one,
	input  wire logic              txc_irq_serviced,
	output var  logic              data_reg_empty_flag,
	output var  logic              transmit_complete_flag,
	output var  logic              receive_complete_flag,
	output var  logic              empty_irq_req,
	output var  logic              tx_complete_irq_req,
	// serial pins
	input  wire logic              rxd_in,
	output var  logic              txd_out,
	output var  logic              txd_oe_n,
	output var  logic              rxd_owned,
	output var  logic              xck_owned
);

	// ---------------- core domain: transmit side ----------------
	logic              tx_req_tgl_reg;
	logic [DATA_W-1:0] tx_buf_reg;
	logic              data_reg_empty_flag_reg;
	logic              tx_inflight_reg;
	logic              tx_active_reg;
	logic              txc_reg;
	logic              ack_s1_reg, ack_s2_reg, ack_s3_reg;
	logic              done_s1_reg, done_s2_reg, done_s3_reg;
	logic              ack_evt, done_evt, wr_ok, txc_set;
	logic              tx_ack_tgl_reg, tx_done_tgl_reg;

	assign ack_evt  = ack_s2_reg ^ ack_s3_reg;
	assign done_evt = done_s2_reg ^ done_s3_reg;
	assign wr_ok    = data_wr && data_reg_empty_flag_reg && transmitter_enable_bit;
	assign txc_set  = done_evt && data_reg_empty_flag_reg;

	always_ff @(posedge core_clk) begin
		ack_s1_reg  <= tx_ack_tgl_reg;
		ack_s2_reg  <= ack_s1_reg;
		ack_s3_reg  <= ack_s2_reg;
		done_s1_reg <= tx_done_tgl_reg;
		done_s2_reg <= done_s1_reg;
		done_s3_reg <= done_s2_reg;
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			tx_req_tgl_reg <= 1'b0;
			tx_buf_reg     <= '0;
			data_reg_empty_flag_reg       <= 1'b1;
		end else begin
			if (wr_ok) begin
				tx_buf_reg     <= mask_char({ninth_transmit_bit, wr_data},
					character_size_code);
				tx_req_tgl_reg <= ~tx_req_tgl_reg;
			end
			if (wr_ok)
				data_reg_empty_flag_reg <= 1'b0;
			else if (ack_evt)
				data_reg_empty_flag_reg <= 1'b1;
		end
	end

	// a frame counts as in flight until the link reports an empty shifter
	always_ff @(posedge core_clk) begin
		if (srst)
			tx_inflight_reg <= 1'b0;
		else if (wr_ok)
			tx_inflight_reg <= 1'b1;
		else if (txc_set)
			tx_inflight_reg <= 1'b0;
	end

	always_ff @(posedge core_clk) begin
		if (srst)
			tx_active_reg <= 1'b0;
		else if (transmitter_enable_bit)
			tx_active_reg <= 1'b1;
		else if (data_reg_empty_flag_reg && !tx_inflight_reg)
			tx_active_reg <= 1'b0;
	end

	always_ff @(posedge core_clk) begin
		if (srst)
			txc_reg <= 1'b0;
		else if (txc_set)
			txc_reg <= 1'b1;
		else if (txc_write_one || txc_irq_serviced)
			txc_reg <= 1'b0;
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			empty_irq_req       <= 1'b0;
			tx_complete_irq_req <= 1'b0;
		end else begin
			empty_irq_req       <= empty_interrupt_enable && data_reg_empty_flag_reg;
			tx_complete_irq_req <= transmit_complete_irq_enable
				&& txc_reg;
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			txd_oe_n  <= 1'b1;
			rxd_owned <= 1'b0;
			xck_owned <= 1'b0;
		end else begin
			txd_oe_n  <= ~tx_active_reg;
			rxd_owned <= receiver_enable_bit;
			xck_owned <= sync_mode
				&& (tx_active_reg || receiver_enable_bit);
		end
	end

	assign data_reg_empty_flag    = data_reg_empty_flag_reg;
	assign transmit_complete_flag = txc_reg;

	// ---------------- core domain: receive store ----------------
	logic                rx_s1_reg, rx_s2_reg, rx_s3_reg;
	logic                rx_evt, store_wr, pop;
	logic [1:0]          rx_count_reg, rx_count_next;
	logic [STORE_AW-1:0] head_reg, head_next, tail_reg;
	logic [DATA_W-1:0]   store_q, rx_word_reg;
	logic                rx_tgl_reg;

	assign rx_evt   = rx_s2_reg ^ rx_s3_reg;
	assign store_wr = rx_evt && receiver_enable_bit
		&& rx_count_reg != STORE_FULL;
	assign pop      = data_rd && rx_count_reg != 2'h0;

	always_ff @(posedge core_clk) begin
		rx_s1_reg <= rx_tgl_reg;
		rx_s2_reg <= rx_s1_reg;
		rx_s3_reg <= rx_s2_reg;
	end

	always_comb begin
		head_next     = pop ? head_reg + 1'b1 : head_reg;
		rx_count_next = rx_count_reg;
		if (!receiver_enable_bit)
			rx_count_next = 2'h0;
		else if (store_wr && !pop)
			rx_count_next = rx_count_reg + 2'h1;
		else if (pop && !store_wr)
			rx_count_next = rx_count_reg - 2'h1;
	end

	always_ff @(posedge core_clk) begin
		if (srst || !receiver_enable_bit) begin
			head_reg              <= '0;
			tail_reg              <= '0;
			rx_count_reg          <= 2'h0;
			receive_complete_flag <= 1'b0;
		end else begin
			head_reg              <= head_next;
			tail_reg              <= store_wr ? tail_reg + 1'b1 : tail_reg;
			rx_count_reg          <= rx_count_next;
			receive_complete_flag <= rx_count_next != 2'h0;
		end
	end

	rx_char_store u_store (
		.clk     (core_clk),
		.wr_en   (store_wr),
		.wr_addr (tail_reg),
		.wr_data (rx_word_reg),
		.rd_addr (head_next),
		.rd_data (store_q)
	);

	assign rd_data           = store_q[7:0];
	assign ninth_receive_bit = store_q[8];

	// ---------------- link domain ----------------
	logic             lrst_s1_reg, lrst_reg;
	logic [CFG_W-1:0] cfg_s1_reg, cfg_reg;
	logic             req_s1_reg, req_s2_reg;
	logic             rxd_s1_reg, rxd_s2_reg, rxd_s3_reg, rx_line_reg;
	logic             l_rx_en, l_sync, l_double, l_par, l_odd, l_stop2;
	logic [2:0]       l_size;
	logic [BAUD_W-1:0] l_baud, presc_reg;
	logic             os_tick;
	logic [4:0]       spb;

	always_ff @(posedge external_transfer_clock_pin) begin
		lrst_s1_reg <= srst;
		lrst_reg    <= lrst_s1_reg;
		cfg_s1_reg  <= {receiver_enable_bit, sync_mode, double_speed_bit,
			character_size_code, parity_enable_bit, parity_type_bit,
			stop_bit_count_select, baud_divisor_high, baud_divisor_low};
		cfg_reg     <= cfg_s1_reg;
		req_s1_reg  <= tx_req_tgl_reg;
		req_s2_reg  <= req_s1_reg;
		rxd_s1_reg  <= rxd_in;
		rxd_s2_reg  <= rxd_s1_reg;
		rxd_s3_reg  <= rxd_s2_reg;
	end

	assign {l_rx_en, l_sync, l_double, l_size, l_par, l_odd, l_stop2,
		l_baud} = cfg_reg;
	assign os_tick = presc_reg == '0;
	assign spb     = l_double ? OS_DOUBLE : OS_NORMAL;

	// receive line changes once the last two sampling stages agree; a sync
	// bit lasts one link edge, so there the agreement test would drop it
	always_ff @(posedge external_transfer_clock_pin) begin
		if (lrst_reg)
			rx_line_reg <= LINE_IDLE;
		else if (l_sync || rxd_s2_reg == rxd_s3_reg)
			rx_line_reg <= rxd_s3_reg;
	end

	always_ff @(posedge external_transfer_clock_pin) begin
		if (lrst_reg || os_tick)
			presc_reg <= l_baud;
		else
			presc_reg <= presc_reg - 1'b1;
	end

	// transmit shifter
	tx_state_e          tx_state_reg;
	logic [FRAME_W-1:0] tx_sh_reg, frame_now;
	logic [3:0]         tx_left_reg, len_now;
	logic [4:0]         tx_os_reg;
	logic               tx_tick, pending;

	assign pending   = req_s2_reg != tx_ack_tgl_reg;
	assign tx_tick   = l_sync ? 1'b1 : (os_tick && tx_os_reg == spb - 5'h1);
	assign frame_now = build_frame(tx_buf_reg, l_size, l_par,
		l_odd);
	assign len_now   = char_bits(l_size) + {3'h0, l_par} + {3'h0, l_stop2}
		+ STOP_ONE + STOP_ONE;

	always_ff @(posedge external_transfer_clock_pin) begin
		if (lrst_reg || tx_state_reg == TX_IDLE)
			tx_os_reg <= 5'h0;
		else if (os_tick)
			tx_os_reg <= (tx_os_reg == spb - 5'h1) ? 5'h0 : tx_os_reg + 5'h1;
	end

	always_ff @(posedge external_transfer_clock_pin) begin
		if (lrst_reg) begin
			tx_state_reg    <= TX_IDLE;
			tx_sh_reg       <= '1;
			tx_left_reg     <= 4'h0;
			tx_ack_tgl_reg  <= 1'b0;
			tx_done_tgl_reg <= 1'b0;
		end else begin
			case (tx_state_reg)
			TX_IDLE: begin
				if (pending) begin
					tx_sh_reg      <= frame_now;
					tx_left_reg    <= len_now;
					tx_ack_tgl_reg <= ~tx_ack_tgl_reg;
					tx_state_reg   <= TX_SHIFT;
				end
			end
			TX_SHIFT: begin
				if (tx_tick && tx_left_reg == STOP_ONE) begin
					if (pending) begin
						tx_sh_reg      <= frame_now;
						tx_left_reg    <= len_now;
						tx_ack_tgl_reg <= ~tx_ack_tgl_reg;
					end else begin
						tx_state_reg    <= TX_IDLE;
						tx_done_tgl_reg <= ~tx_done_tgl_reg;
					end
				end else if (tx_tick) begin
					tx_sh_reg   <= {LINE_IDLE, tx_sh_reg[FRAME_W-1:1]};
					tx_left_reg <= tx_left_reg - 4'h1;
				end
			end
			default: tx_state_reg <= TX_IDLE;
			endcase
		end
	end

	always_ff @(posedge external_transfer_clock_pin) begin
		if (lrst_reg || tx_state_reg != TX_SHIFT)
			txd_out <= LINE_IDLE;
		else
			txd_out <= tx_sh_reg[0];
	end

	// receive shifter
	rx_state_e       rx_state_reg;
	logic [4:0]      rx_os_reg;
	logic [3:0]      rx_cnt_reg, rx_total;
	logic [RX_W-1:0] rx_sh_reg, rx_sh_next, rx_aligned;
	logic            rx_sample;

	assign rx_total   = char_bits(l_size) + {3'h0, l_par} + STOP_ONE;
	assign rx_sample  = l_sync ? 1'b1 : (os_tick && rx_os_reg == spb - 5'h1);
	assign rx_sh_next = {rx_line_reg, rx_sh_reg[RX_W-1:1]};
	assign rx_aligned = rx_sh_next >> (RX_BITS - rx_total);

	always_ff @(posedge external_transfer_clock_pin) begin
		if (lrst_reg) begin
			rx_state_reg <= RX_IDLE;
			rx_os_reg    <= 5'h0;
			rx_cnt_reg   <= 4'h0;
			rx_sh_reg    <= '0;
			rx_word_reg  <= '0;
			rx_tgl_reg   <= 1'b0;
		end else if (!l_rx_en) begin
			rx_state_reg <= RX_IDLE;
		end else begin
			case (rx_state_reg)
			RX_IDLE: begin
				rx_os_reg  <= 5'h0;
				rx_cnt_reg <= 4'h0;
				if (rx_line_reg == START_BIT && l_sync)
					rx_state_reg <= RX_DATA;
				else if (rx_line_reg == START_BIT && os_tick)
					rx_state_reg <= RX_START;
			end
			RX_START: begin
				if (os_tick && rx_os_reg == (spb >> 1) - 5'h1) begin
					rx_os_reg    <= 5'h0;
					rx_state_reg <= (rx_line_reg == START_BIT) ? RX_DATA
						: RX_IDLE;
				end else if (os_tick)
					rx_os_reg <= rx_os_reg + 5'h1;
			end
			RX_DATA: begin
				if (os_tick)
					rx_os_reg <= (rx_os_reg == spb - 5'h1) ? 5'h0
						: rx_os_reg + 5'h1;
				if (rx_sample) begin
					rx_sh_reg  <= rx_sh_next;
					rx_cnt_reg <= rx_cnt_reg + 4'h1;
					if (rx_cnt_reg + 4'h1 == rx_total) begin
						rx_word_reg  <= mask_char(rx_aligned[DATA_W-1:0],
							l_size);
						rx_tgl_reg   <= ~rx_tgl_reg;
						rx_state_reg <= RX_IDLE;
					end
				end
			end
			default: rx_state_reg <= RX_IDLE;
			endcase
		end
	end

	// ---------------- assertions ----------------
	a_write_clears_empty: assert property (
		@(posedge core_clk) disable iff (srst)
		wr_ok |=> !data_reg_empty_flag [*2])
		else $error("empty flag not cleared by data write");
	a_empty_irq_level: assert property (
		@(posedge core_clk) disable iff (srst)
		(empty_interrupt_enable && data_reg_empty_flag_reg) [*2] |-> empty_irq_req)
		else $error("empty interrupt not requested");
	a_txc_irq_rise: assert property (
		@(posedge core_clk) disable iff (srst)
		$rose(txc_reg) && transmit_complete_irq_enable |=> tx_complete_irq_req)
		else $error("complete interrupt missing");
	a_txc_set_wins: assert property (
		@(posedge core_clk) disable iff (srst)
		txc_set |=> transmit_complete_flag)
		else $error("complete flag not set after frame");
	a_txc_clears: assert property (
		@(posedge core_clk) disable iff (srst)
		(txc_write_one || txc_irq_serviced) && !txc_set |=> !txc_reg)
		else $error("complete flag not cleared");
	a_rx_flush: assert property (
		@(posedge core_clk) disable iff (srst)
		!receiver_enable_bit |=> !receive_complete_flag && rx_count_reg == 2'h0)
		else $error("receive store not flushed");
	a_store_depth: assert property (
		@(posedge core_clk) disable iff (srst)
		rx_count_reg <= STORE_FULL)
		else $error("receive store overfilled");
	a_disable_holds: assert property (
		@(posedge core_clk) disable iff (srst)
		!data_reg_empty_flag_reg ##1 !transmitter_enable_bit |=> !txd_oe_n)
		else $error("pin released with data waiting");
	a_idle_high: assert property (
		@(posedge external_transfer_clock_pin) disable iff (lrst_reg)
		tx_state_reg == TX_IDLE ##1 tx_state_reg == TX_IDLE |=> txd_out)
		else $error("idle transmit line not high");
	a_start_low: assert property (
		@(posedge external_transfer_clock_pin) disable iff (lrst_reg)
		tx_state_reg == TX_IDLE && pending |=> ##1 !txd_out)
		else $error("start bit not low");

	c_tx_done: cover property (@(posedge core_clk) disable iff (srst)
		txc_set);
	c_rx_stored: cover property (@(posedge core_clk) disable iff (srst)
		store_wr);
	c_store_full: cover property (@(posedge core_clk) disable iff (srst)
		rx_count_reg == STORE_FULL);
	c_back_to_back: cover property (
		@(posedge external_transfer_clock_pin) disable iff (lrst_reg)
		tx_tick && tx_left_reg == STOP_ONE && pending);

endmodule

`default_nettype wire

// File: testbench/serial_peer.sv
/*
 * Remote serial peer on the transmit and receive lines.
 * Assumes one bit per link clock period: the device changes its line on
 * the rising edge, the peer samples and drives on the falling edge.
 */
`timescale 1ns/100ps
`default_nettype none

module serial_peer (
	// link
	input  wire logic       link_clk,
	input  wire logic       txd,
	output var  logic       rxd,
	// frame format
	input  wire logic [3:0] nbits,
	input  wire logic       par_en,
	input  wire logic       odd
);
	logic [8:0] got_d;
	logic       got_p;
	logic       got_s;
	int         got_n = 0;

	// receive line has a pull-up, so the released level is high
	initial rxd = 1'b1;

	// start, data lsb first, parity, first stop
	always @(negedge link_clk) begin
		if (txd === 1'b0) begin
			got_d = '0;
			for (int k = 0; k < nbits; k++) begin
				@(negedge link_clk);
				got_d[k] = txd;
			end
			if (par_en) begin
				@(negedge link_clk);
				got_p = txd;
			end
			@(negedge link_clk);
			got_s = txd;
			got_n++;
		end
	end

	task automatic send(input logic [8:0] d, input int stops);
		logic [12:0] f;
		logic        p;
		int          n;
		f = '1;
		f[0] = 1'b0;
		p = odd;
		for (int i = 0; i < nbits; i++) begin
			f[i + 1] = d[i];
			p = p ^ d[i];
		end
		n = nbits + 1;
		if (par_en) begin
			f[n] = p;
			n++;
		end
		n = n + stops;
		for (int i = 0; i < n; i++) begin
			@(negedge link_clk);
			rxd = f[i];
		end
	endtask
endmodule

`default_nettype wire

// File: testbench/tb_usart_tx_rx_datapath.sv
/*
 * Self-checking bench of the serial data path against a remote peer.
 * Assumes synchronous framing: the link clock is the bit clock.
 */
`timescale 1ns/100ps
`default_nettype none

module tb_usart_tx_rx_datapath;
	import usart_pkg::*;

	logic       core_clk = 1'b0;
	logic       link_clk = 1'b0;
	logic       srst     = 1'b1;
	logic       sy       = 1'b1;
	logic       ten = 1'b0, ren = 1'b0, wr = 1'b0, rd = 1'b0;
	logic       pen = 1'b0, pty = 1'b0, s2 = 1'b0, n9 = 1'b0;
	logic       e_ie = 1'b0, c_ie = 1'b0, w1 = 1'b0, srv = 1'b0;
	logic [2:0] csz      = 3'h3;
	logic [3:0] nb       = 4'h8;
	logic [7:0] wd       = 8'h00;
	logic [7:0] rdat;
	logic       rb8, empty_f, done_f, rcv_f, e_irq, c_irq;
	logic       txd, oe_n, rown, xown, rxd, tx_line;
	int         fail_count = 0;
	int         cmp_count  = 0;
	logic [2:0] codes [5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h7};

	always #10 core_clk = ~core_clk;
	initial begin
		#3.3;
		forever #7.5 link_clk = ~link_clk;
	end

	// transmit line is pulled high while the device lets go of it
	assign tx_line = oe_n ? 1'b1 : txd;

	usart_tx_rx_datapath dut_u (
		.core_clk(core_clk), .srst(srst),
		.external_transfer_clock_pin(link_clk),
		.transmitter_enable_bit(ten), .receiver_enable_bit(ren),
		.sync_mode(sy), .double_speed_bit(1'b0),
		.character_size_code(csz), .parity_enable_bit(pen),
		.parity_type_bit(pty), .stop_bit_count_select(s2),
		.baud_divisor_high(4'h0), .baud_divisor_low(8'h00),
		.data_wr(wr), .wr_data(wd), .ninth_transmit_bit(n9),
		.data_rd(rd), .rd_data(rdat), .ninth_receive_bit(rb8),
		.empty_interrupt_enable(e_ie),
		.transmit_complete_irq_enable(c_ie),
		.txc_write_one(w1), .txc_irq_serviced(srv),
		.data_reg_empty_flag(empty_f), .transmit_complete_flag(done_f),
		.receive_complete_flag(rcv_f), .empty_irq_req(e_irq),
		.tx_complete_irq_req(c_irq), .rxd_in(rxd), .txd_out(txd),
		.txd_oe_n(oe_n), .rxd_owned(rown), .xck_owned(xown)
	);

	serial_peer peer_u (
		.link_clk(link_clk), .txd(tx_line), .rxd(rxd),
		.nbits(nb), .par_en(pen), .odd(pty)
	);

	task automatic check(input string nm, input logic [8:0] seen,
			input logic [8:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			fail_count++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic wait_for(ref logic s, input logic v, input string nm);
		for (int i = 0; i < 500 && s !== v; i++)
			@(negedge core_clk);
		check(nm, s, v);
	endtask

	task automatic wait_frames(input int n);
		for (int i = 0; i < 2000 && peer_u.got_n < n; i++)
			@(negedge core_clk);
		check("frames", 9'(peer_u.got_n), 9'(n));
	endtask

	function automatic logic [8:0] msk(input logic [8:0] d);
		return d & ((9'h1 << nb) - 9'h1);
	endfunction

	task automatic cfg(input logic [2:0] c, input logic p, input logic o);
		@(posedge core_clk);
		csz <= c;
		pen <= p;
		pty <= o;
		s2 <= o;
		nb <= (c == 3'h7) ? 4'h9 : (c[2] ? 4'h8 : 4'h5 + {2'h0, c[1:0]});
		repeat (8) @(posedge core_clk);
	endtask

	task automatic put(input logic [8:0] d);
		@(posedge core_clk);
		n9 <= d[8];
		@(posedge core_clk);
		wd <= d[7:0];
		wr <= 1'b1;
		@(posedge core_clk);
		wr <= 1'b0;
		@(negedge core_clk);
		check("empty_flag", empty_f, 1'b0);
	endtask

	task automatic pop();
		@(posedge core_clk);
		rd <= 1'b1;
		@(posedge core_clk);
		rd <= 1'b0;
		@(negedge core_clk);
	endtask

	task automatic tx_frame(input logic [8:0] d);
		int n;
		n = peer_u.got_n;
		put(d);
		wait_frames(n + 1);
		check("tx_data", peer_u.got_d, msk(d));
		if (pen)
			check("tx_parity", peer_u.got_p, ^msk(d) ^ pty);
		check("tx_stop", peer_u.got_s, 1'b1);
		wait_for(done_f, 1'b1, "complete_flag");
		@(negedge core_clk);
		check("complete_irq", c_irq, 1'b1);
		@(posedge core_clk);
		if (d[4])
			srv <= 1'b1;
		else
			w1 <= 1'b1;
		@(posedge core_clk);
		srv <= 1'b0;
		w1 <= 1'b0;
		@(negedge core_clk);
		check("complete_cleared", done_f, 1'b0);
		@(negedge core_clk);
		check("complete_irq_off", c_irq, 1'b0);
	endtask

	task automatic tx_modes();
		@(posedge core_clk);
		ten <= 1'b1;
		c_ie <= 1'b1;
		repeat (6) @(negedge core_clk);
		check("tx_owned", oe_n, 1'b0);
		check("tx_idle", txd, 1'b1);
		check("xck_owned", xown, 1'b1);
		foreach (codes[i])
			for (int p = 1; p < 4; p++) begin
				cfg(codes[i], p[1], p[0]);
				tx_frame(9'h0a5 ^ {codes[i], p[1:0], 4'h0});
			end
	endtask

	task automatic tx_back_to_back();
		int n;
		n = peer_u.got_n;
		@(posedge core_clk);
		e_ie <= 1'b1;
		@(negedge core_clk);
		@(negedge core_clk);
		check("empty_irq_idle", e_irq, 1'b1);
		put(9'h0c3);
		@(negedge core_clk);
		check("empty_irq_busy", e_irq, 1'b0);
		wait_for(empty_f, 1'b1, "empty_after_load");
		put(9'h13c);
		wait_frames(n + 1);
		check("first_data", peer_u.got_d, msk(9'h0c3));
		repeat (4) @(negedge core_clk);
		check("no_early_complete", done_f, 1'b0);
		wait_frames(n + 2);
		check("second_data", peer_u.got_d, msk(9'h13c));
		wait_for(done_f, 1'b1, "complete_after_two");
		@(posedge core_clk);
		e_ie <= 1'b0;
		w1 <= 1'b1;
		@(posedge core_clk);
		w1 <= 1'b0;
	endtask

	task automatic tx_disable();
		int n;
		n = peer_u.got_n;
		put(9'h05a);
		@(posedge core_clk);
		ten <= 1'b0;
		repeat (3) @(negedge core_clk);
		check("still_owned", oe_n, 1'b0);
		wait_frames(n + 1);
		check("drained_data", peer_u.got_d, msk(9'h05a));
		wait_for(oe_n, 1'b1, "released");
		check("xck_released", xown, 1'b0);
	endtask

	task automatic rx_frame(input logic [8:0] d, input int stops);
		peer_u.send(d, stops);
		wait_for(rcv_f, 1'b1, "receive_flag");
		check("rx_data", {rb8, rdat}, msk(d));
		pop();
		check("rx_popped", rcv_f, 1'b0);
	endtask

	task automatic rx_modes();
		@(posedge core_clk);
		ren <= 1'b1;
		sy <= 1'b0;
		repeat (6) @(negedge core_clk);
		check("rx_owned", rown, 1'b1);
		check("xck_async", xown, 1'b0);
		@(posedge core_clk);
		sy <= 1'b1;
		repeat (6) @(negedge core_clk);
		check("xck_sync", xown, 1'b1);
		foreach (codes[i]) begin
			cfg(codes[i], i[0], i[1]);
			rx_frame(9'h0a5 ^ {codes[i], 6'h00}, 1 + i[1]);
		end
	endtask

	task automatic rx_store();
		peer_u.send(9'h011, 1);
		peer_u.send(9'h022, 1);
		peer_u.send(9'h033, 1);
		repeat (20) @(negedge core_clk);
		for (int i = 1; i < 3; i++) begin
			check("store_flag", rcv_f, 1'b1);
			check("store_data", {rb8, rdat}, msk(9'(i * 17)));
			pop();
		end
		if (rcv_f === 1'b1)
			pop();
		peer_u.send(9'h044, 1);
		wait_for(rcv_f, 1'b1, "flush_fill");
		@(posedge core_clk);
		ren <= 1'b0;
		repeat (2) @(negedge core_clk);
		check("flushed", rcv_f, 1'b0);
		check("rx_released", rown, 1'b0);
	endtask

	task automatic summarize();
		$display("checks %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	initial begin
		#200000;
		fail_count++;
		$display("ERROR watchdog expected done seen hang");
		summarize();
	end

	initial begin
		repeat (5) @(posedge core_clk);
		srst <= 1'b0;
		@(negedge core_clk);
		check("reset_empty", empty_f, 1'b1);
		check("reset_oe_n", oe_n, 1'b1);
		check("reset_rcv", rcv_f, 1'b0);
		tx_modes();
		tx_back_to_back();
		tx_disable();
		rx_modes();
		rx_store();
		summarize();
	end
endmodule

`default_nettype wire
